// file: logic/usp_pkg.sv
/*
  Constants, register map and state codes of the serial port block.
  Assumes an APB slave with byte addresses and 32-bit data.
*/
//------------------------------------------------------------
// Overview of operation
//------------------------------------------------------------
// Overview of operation
// - Sixteen-byte receive and transmit FIFOs
// - Line control sets length, parity, stop bits
// - Divisor latch access swaps buffer/enable to divisor
// - Divisor counts clock into sixteen-times baud ticks
// - Zero divisor stops all serial traffic
// - Divisor is zero after reset
// - FIFOs off after reset, enabled by control
// - No request/clear-to-send pins exposed
// - Fixed priority: error, data, timeout, transmit
// - Character timeout only in FIFO mode
// - Threshold mode: interrupt at or below level
// - Shared address: identity read, FIFO control write
// - Transmit trigger field binary 10 means quarter full
// - Enable bit selects programmable threshold mode only in FIFO mode
package usp_pkg;

  // Bus and data widths
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned CNT_W      = 5;

  // Register byte addresses
  localparam logic [7:0] ADDR_BUF   = 8'h00;
  localparam logic [7:0] ADDR_IEN   = 8'h04;
  localparam logic [7:0] ADDR_IIF   = 8'h08;
  localparam logic [7:0] ADDR_LCTL  = 8'h0C;
  localparam logic [7:0] ADDR_MCTL  = 8'h10;
  localparam logic [7:0] ADDR_LSTA  = 8'h14;
  localparam logic [7:0] ADDR_MSTA  = 8'h18;
  localparam logic [7:0] ADDR_SCR   = 8'h1C;
  localparam logic [7:0] ADDR_EVS   = 8'h20;
  localparam logic [7:0] ADDR_EVM   = 8'h24;
  localparam logic [7:0] ADDR_PSTA  = 8'h7C;

  // Interrupt identity codes, low nibble of the identity read
  localparam logic [3:0] IID_NONE = 4'h1;
  localparam logic [3:0] IID_LINE = 4'h6;
  localparam logic [3:0] IID_RXAV = 4'h4;
  localparam logic [3:0] IID_TOUT = 4'hC;
  localparam logic [3:0] IID_TX_HOLDING_EMPTY = 4'h2;

  // Enable register bits
  localparam int unsigned IEN_RX   = 0;
  localparam int unsigned IEN_TX   = 1;
  localparam int unsigned IEN_LINE = 2;
  localparam int unsigned IEN_PROG = 7;

  // Line control bits
  localparam int unsigned LC_STOP = 2;
  localparam int unsigned LC_PEN  = 3;
  localparam int unsigned LC_EPS  = 4;
  localparam int unsigned LC_BRK  = 6;
  localparam int unsigned LC_DIVISOR_LATCH_ACCESS = 7;

  // FIFO control bits
  localparam int unsigned FC_EN  = 0;
  localparam int unsigned FC_RXR = 1;
  localparam int unsigned FC_TXR = 2;

  // Oversampling: ticks per bit and the mid-bit tick
  localparam logic [3:0] TICK_LAST = 4'hF;
  localparam logic [3:0] TICK_MID  = 4'h7;

  // Character timeout: four frames of ten bits at 16 ticks
  localparam logic [9:0] TOUT_TICKS = 10'h280;

  // Serial engine states, one-hot
  typedef enum logic [4:0] {
    SER_IDLE  = 5'b00001,
    SER_START = 5'b00010,
    SER_DATA  = 5'b00100,
    SER_PAR   = 5'b01000,
    SER_STOP  = 5'b10000
  } usp_ser_state_t;

endpackage

// file: logic/usp_fifo_if.sv
/*
  Bundle between the serial port core and one FIFO store.
  Assumes both ends sit on the same clock.
*/
`timescale 1ns/1ps
interface usp_fifo_if;
  logic                     push;  // Write strobe
  logic [7:0]               wdata; // Write byte
  logic                     pop;   // Read strobe, only while valid
  logic [7:0]               rdata; // Head byte, registered
  logic                     valid; // Head byte present
  logic [usp_pkg::CNT_W-1:0] count; // Bytes held
  logic                     flush; // Empty the store

  modport fill  (output push, wdata, pop, flush,
                 input  rdata, valid, count);
  modport store (input  push, wdata, pop, flush,
                 output rdata, valid, count);
endinterface

// file: logic/usp_fifo.sv
/*
  Byte FIFO store with registered head output.
  Assumes pop only while valid and push only when not full.
*/
`timescale 1ns/1ps
module usp_fifo #(
  parameter int unsigned DEPTH = usp_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic    pclk,
  input wire logic    presetn,
  // Core side
  usp_fifo_if.store   f
);
  import usp_pkg::*;

  localparam int unsigned PW = $clog2(DEPTH);

  logic [7:0]       mem [DEPTH]; // Storage
  logic [PW-1:0]    wr_ptr;      // Next write slot
  logic [PW-1:0]    rd_ptr;      // Head slot

  // Storage writes
  always_ff @(posedge pclk) begin
    if (f.push) begin
      mem[wr_ptr] <= f.wdata;
    end
  end

  // Pointers, count, registered head; valid drops for a cycle on pop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr  <= '0;
      rd_ptr  <= '0;
      f.count <= '0;
      f.valid <= 1'b0;
      f.rdata <= 8'h00;
    end else if (f.flush) begin
      wr_ptr  <= '0;
      rd_ptr  <= '0;
      f.count <= '0;
      f.valid <= 1'b0;
    end else begin
      wr_ptr  <= f.push ? PW'(wr_ptr + 1'b1) : wr_ptr;
      rd_ptr  <= f.pop ? PW'(rd_ptr + 1'b1) : rd_ptr;
      f.count <= CNT_W'(f.count + CNT_W'(f.push) - CNT_W'(f.pop));
      f.valid <= (f.count != '0) && !f.pop;
      f.rdata <= mem[rd_ptr];
    end
  end
endmodule

// file: logic/usp_top.sv
/*
  Serial port core: APB registers, baud generator, transmitter,
  receiver, interrupt identification and event status.
  Assumes one clock pclk and an asynchronous serial peer on rxd.
*/
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ps
module usp_top (
  // Clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // APB slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [usp_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                 pwdata,
  output      logic [31:0]                 prdata,
  output      logic                        pready,
  output      logic                        pslverr,
  // Serial line; no flow-control pins exist
  input  wire logic                        rxd,
  output      logic                        txd,
  // Interrupt
  output      logic                        irq
);
  import usp_pkg::*;

  //------------------------------------------------------------
  // Registers and FIFOs
  //------------------------------------------------------------
  logic [7:0]  div_lo;      // Divisor low byte
  logic [7:0]  div_hi;      // Divisor high byte
  logic [7:0]  ien;         // Interrupt enables
  logic [7:0]  lctl;        // Line control
  logic [4:0]  mctl;        // Modem control, storage only
  logic [7:0]  scratch_reg;         // Scratch
  logic        fen;         // FIFO mode
  logic [1:0]  rx_trig;     // Receive trigger select
  logic [1:0]  tx_trig;     // Transmit empty trigger select
  logic        err_ovr;     // Overrun, sticky
  logic        err_par;     // Parity error, sticky
  logic        err_frm;     // Framing error, sticky
  logic [3:0]  evs;         // Event status, write one to clear
  logic [3:0]  evm;         // Event mask

  usp_fifo_if rxf ();
  usp_fifo_if txf ();

  // Receive and transmit stores
  usp_fifo #(.DEPTH(FIFO_DEPTH)) u_rxf (
    .pclk    (pclk),
    .presetn (presetn),
    .f       (rxf.store)
  );
  usp_fifo #(.DEPTH(FIFO_DEPTH)) u_txf (
    .pclk    (pclk),
    .presetn (presetn),
    .f       (txf.store)
  );

  //------------------------------------------------------------
  // APB decode
  //------------------------------------------------------------
  wire        acc     = psel & penable;
  wire        first   = acc & ~pready;     // Data latched here
  wire        done    = acc & pready;      // Effects happen here
  wire        wr      = done & pwrite;
  wire        rd      = done & ~pwrite;
  wire        divisor_latch_access    = lctl[LC_DIVISOR_LATCH_ACCESS];
  wire        a_buf   = paddr == ADDR_BUF;
  wire        a_ien   = paddr == ADDR_IEN;
  wire        a_iif   = paddr == ADDR_IIF;
  wire        a_lctl  = paddr == ADDR_LCTL;
  wire        a_mctl  = paddr == ADDR_MCTL;
  wire        a_lsta  = paddr == ADDR_LSTA;
  wire        a_msta  = paddr == ADDR_MSTA;
  wire        a_scr   = paddr == ADDR_SCR;
  wire        a_evs   = paddr == ADDR_EVS;
  wire        a_evm   = paddr == ADDR_EVM;
  wire        a_psta  = paddr == ADDR_PSTA;
  wire        hit     = a_buf | a_ien | a_iif | a_lctl | a_mctl |
                        a_lsta | a_msta | a_scr | a_evs | a_evm |
                        a_psta;
  // Divisor access replaces buffer and enable while set
  wire        wr_dll  = wr & a_buf & divisor_latch_access;
  wire        wr_dlm  = wr & a_ien & divisor_latch_access;
  wire        wr_thr  = wr & a_buf & ~divisor_latch_access;
  wire        wr_ien  = wr & a_ien & ~divisor_latch_access;
  wire        wr_fcr  = wr & a_iif;
  wire        rd_lsr  = rd & a_lsta;

  //------------------------------------------------------------
  // FIFO fill levels and strobes
  //------------------------------------------------------------
  wire [4:0]  tx_cnt  = txf.count;
  wire [4:0]  rx_cnt  = rxf.count;
  // With FIFOs off each side holds one byte
  wire        tx_full = fen ? (tx_cnt == 5'(FIFO_DEPTH))
                            : (tx_cnt != 5'h00);
  wire        rx_full = fen ? (rx_cnt == 5'(FIFO_DEPTH))
                            : (rx_cnt != 5'h00);
  wire        fcr_fen = pwdata[FC_EN];
  wire        fen_chg = wr_fcr & (fcr_fen != fen);
  logic       rx_push;                      // Receiver push pulse
  logic [7:0] rx_word;                      // Received byte
  logic       tx_pop;                       // Transmitter pop

  assign rxf.push  = rx_push & ~rx_full;
  assign rxf.wdata = rx_word;
  assign rxf.pop   = rd & a_buf & ~divisor_latch_access & rxf.valid;
  assign rxf.flush = fen_chg | (wr_fcr & pwdata[FC_RXR]);
  assign txf.push  = wr_thr & ~tx_full;
  assign txf.wdata = pwdata[7:0];
  assign txf.pop   = tx_pop;
  assign txf.flush = fen_chg | (wr_fcr & pwdata[FC_TXR]);

  //------------------------------------------------------------
  // Baud generator: one tick per divisor clocks
  //------------------------------------------------------------
  wire [15:0] divisor = {div_hi, div_lo};
  wire        div_on  = divisor != 16'h0000;
  logic [15:0] bcnt;                              // Tick prescaler
  wire        btick   = div_on && (bcnt >= 16'(divisor - 16'h0001));

  // Prescaler held at zero while the divisor is zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bcnt <= 16'h0000;
    end else begin
      bcnt <= (btick | ~div_on) ? 16'h0000 : 16'(bcnt + 16'h0001);
    end
  end

  //------------------------------------------------------------
  // Frame format
  //------------------------------------------------------------
  wire [2:0]  last_bit = {1'b1, lctl[1:0]};   // Data bits minus one
  wire [7:0]  len_mask = 8'hFF >> (3'h7 - last_bit);
  wire        stop_two = lctl[LC_STOP];
  wire        par_on   = lctl[LC_PEN];
  wire        par_even = lctl[LC_EPS];

  //------------------------------------------------------------
  // Transmitter
  //------------------------------------------------------------
  usp_ser_state_t tx_st;                   // Transmit state
  logic [3:0] tx_sub;                      // Tick within bit
  logic [2:0] tx_bit;                      // Bit index
  logic [7:0] tx_sh;                       // Shift register
  logic       tx_par;                      // Parity to send
  logic       tx_line;                     // Line before break
  wire        tx_end   = btick && (tx_sub == TICK_LAST);
  wire [7:0]  tx_bits  = txf.rdata & len_mask;
  assign tx_pop = (tx_st == SER_IDLE) & btick & txf.valid;

  // Bit sequencer, advanced only by baud ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st   <= SER_IDLE;
      tx_sub  <= 4'h0;
      tx_bit  <= 3'h0;
      tx_sh   <= 8'h00;
      tx_par  <= 1'b0;
      tx_line <= 1'b1;
    end else begin
      if (btick) begin
        tx_sub <= 4'(tx_sub + 4'h1);
      end
      case (tx_st)
        SER_IDLE: begin
          if (tx_pop) begin                // Start bit
            tx_st   <= SER_START;
            tx_sub  <= 4'h0;
            tx_sh   <= tx_bits;
            tx_par  <= ^tx_bits ^ ~par_even;
            tx_line <= 1'b0;
          end
        end
        SER_START: begin
          if (tx_end) begin                // First data bit, LSB
            tx_st   <= SER_DATA;
            tx_bit  <= 3'h0;
            tx_line <= tx_sh[0];
            tx_sh   <= tx_sh >> 1;
          end
        end
        SER_DATA: begin
          if (tx_end && tx_bit == last_bit) begin
            tx_st   <= par_on ? SER_PAR : SER_STOP;
            tx_line <= par_on ? tx_par : 1'b1;
            tx_bit  <= 3'h0;
          end else if (tx_end) begin
            tx_bit  <= 3'(tx_bit + 3'h1);
            tx_line <= tx_sh[0];
            tx_sh   <= tx_sh >> 1;
          end
        end
        SER_PAR: begin
          if (tx_end) begin
            tx_st   <= SER_STOP;
            tx_line <= 1'b1;
          end
        end
        SER_STOP: begin
          if (tx_end && (tx_bit[0] | ~stop_two)) begin
            tx_st  <= SER_IDLE;
          end else if (tx_end) begin       // Second stop bit
            tx_bit <= 3'h1;
          end
        end
        default: tx_st <= SER_IDLE;
      endcase
    end
  end

  //------------------------------------------------------------
  // Receiver
  //------------------------------------------------------------
  logic       rx_m;                        // First sync stage
  logic       rx_s;                        // Synchronised line
  usp_ser_state_t rx_st;                   // Receive state
  logic [3:0] rx_sub;                      // Tick within bit
  logic [2:0] rx_bit;                      // Bit index
  logic [7:0] rx_sh;                       // Shift register
  logic       rx_pbit;                     // Received parity bit
  wire        rx_mid   = btick && (rx_sub == TICK_MID);
  wire        rx_end   = btick && (rx_sub == TICK_LAST);
  wire [7:0]  rx_data  = rx_sh >> (3'h7 - last_bit);
  wire        rx_pbad  = par_on & (rx_pbit != (^rx_data ^ ~par_even));

  // Two-stage synchroniser on the line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_m <= 1'b1;
      rx_s <= 1'b1;
    end else begin
      rx_m <= rxd;
      rx_s <= rx_m;
    end
  end

  // Low line at a baud tick in idle starts a frame, bits sampled mid-cell
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st   <= SER_IDLE;
      rx_sub  <= 4'h0;
      rx_bit  <= 3'h0;
      rx_sh   <= 8'h00;
      rx_pbit <= 1'b0;
      rx_push <= 1'b0;
      rx_word <= 8'h00;
    end else begin
      rx_push <= 1'b0;
      if (btick) begin
        rx_sub <= 4'(rx_sub + 4'h1);
      end
      case (rx_st)
        SER_IDLE: begin
          if (btick && !rx_s) begin
            rx_st  <= SER_START;
            rx_sub <= 4'h0;
          end
        end
        SER_START: begin
          if (rx_mid && rx_s) begin        // Glitch, not a start
            rx_st <= SER_IDLE;
          end else if (rx_mid) begin       // Realign to mid-bit
            rx_st  <= SER_DATA;
            rx_sub <= 4'h0;
            rx_bit <= 3'h0;
          end
        end
        SER_DATA: begin
          if (rx_end) begin
            rx_sh  <= {rx_s, rx_sh[7:1]};
            rx_bit <= 3'(rx_bit + 3'h1);
            if (rx_bit == last_bit) begin
              rx_st <= par_on ? SER_PAR : SER_STOP;
            end
          end
        end
        SER_PAR: begin
          if (rx_end) begin
            rx_pbit <= rx_s;
            rx_st   <= SER_STOP;
          end
        end
        SER_STOP: begin
          if (rx_end) begin
            rx_push <= 1'b1;
            rx_word <= rx_data;
            rx_st   <= SER_IDLE;
          end
        end
        default: rx_st <= SER_IDLE;
      endcase
    end
  end

  // Line errors captured with the stop bit
  wire rx_stop_end = (rx_st == SER_STOP) & rx_end;
  wire set_frm     = rx_stop_end & ~rx_s;
  wire set_par     = rx_stop_end & rx_pbad;
  wire set_ovr     = rx_push & rx_full;

  //------------------------------------------------------------
  // Character timeout, FIFO mode only
  //------------------------------------------------------------
  logic [9:0] tout_cnt;                    // Idle ticks with data
  wire        tout_hit = fen & rxf.valid & (tout_cnt == TOUT_TICKS);

  // Restarts on any push or pop, saturates at the limit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tout_cnt <= 10'h000;
    end else if (rxf.push | rxf.pop | ~fen | ~rxf.valid) begin
      tout_cnt <= 10'h000;
    end else if (btick && !tout_hit) begin
      tout_cnt <= 10'(tout_cnt + 10'h001);
    end
  end

  //------------------------------------------------------------
  // Interrupt sources and identification
  //------------------------------------------------------------
  wire [4:0] rx_lvl = (rx_trig == 2'b00) ? 5'h01 :
                      (rx_trig == 2'b01) ? 5'h04 :
                      (rx_trig == 2'b10) ? 5'h08 : 5'h0E;
  // Binary 10 selects a quarter of the FIFO
  wire [4:0] tx_lvl = (tx_trig == 2'b00) ? 5'h00 :
                      (tx_trig == 2'b01) ? 5'h02 :
                      (tx_trig == 2'b10) ? 5'h04 : 5'h08;
  wire       prog   = ien[IEN_PROG] & fen;
  wire       rx_rdy = fen ? (rx_cnt >= rx_lvl) : rxf.valid;
  wire       tx_holding_empty   = prog ? (tx_cnt <= tx_lvl)
                           : (tx_cnt == 5'h00);
  wire       src_ln = ien[IEN_LINE] & (err_ovr | err_par | err_frm);
  wire       src_rx = ien[IEN_RX] & rx_rdy;
  wire       src_to = ien[IEN_RX] & tout_hit;
  wire       src_tx = ien[IEN_TX] & tx_holding_empty;
  wire [3:0] iid    = src_ln ? IID_LINE :
                      src_rx ? IID_RXAV :
                      src_to ? IID_TOUT :
                      src_tx ? IID_TX_HOLDING_EMPTY : IID_NONE;
  wire [3:0] src    = {src_tx, src_to, src_rx, src_ln};

  //------------------------------------------------------------
  // Read data
  //------------------------------------------------------------
  wire tx_idle = (tx_st == SER_IDLE);
  wire [7:0] line_status_reg = {err_par | err_frm, tx_idle & (tx_cnt == 5'h00),
                    tx_cnt == 5'h00, 1'b0, err_frm, err_par, err_ovr,
                    rxf.valid};
  wire [7:0] psr = {3'h0, rx_full, rxf.valid, tx_cnt == 5'h00,
                    ~tx_full, ~tx_idle | ~rx_st[0]};
  // Identity in bits 3:0 on read
  wire [7:0] iir = {fen, fen, 2'b00, iid};
  wire [7:0] rd_mux =
    (a_buf & divisor_latch_access)  ? div_lo :
    a_buf           ? rxf.rdata :
    (a_ien & divisor_latch_access)  ? div_hi :
    a_ien           ? ien :
    a_iif           ? iir :
    a_lctl          ? lctl :
    a_mctl          ? {3'h0, mctl} :
    a_lsta          ? line_status_reg :
    a_scr           ? scratch_reg :
    a_evs           ? {4'h0, evs} :
    a_evm           ? {4'h0, evm} :
    a_psta          ? psr : 8'h00;

  //------------------------------------------------------------
  // APB answer: one wait state, registered outputs
  //------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= first;
      pslverr <= first & ~hit;
      if (first) begin
        prdata <= {24'h00_0000, rd_mux};
      end
    end
  end

  //------------------------------------------------------------
  // Control registers; divisor and FIFO mode reset to off
  //------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_lo  <= 8'h00;
      div_hi  <= 8'h00;
      ien     <= 8'h00;
      lctl    <= 8'h03;
      mctl    <= 5'h00;
      scratch_reg     <= 8'h00;
      fen     <= 1'b0;
      rx_trig <= 2'b00;
      tx_trig <= 2'b00;
      evm     <= 4'h0;
    end else begin
      if (wr_dll) div_lo <= pwdata[7:0];
      if (wr_dlm) div_hi <= pwdata[7:0];
      if (wr_ien) ien <= pwdata[7:0] & 8'h87;
      if (wr & a_lctl) lctl <= pwdata[7:0];
      if (wr & a_mctl) mctl <= pwdata[4:0];
      if (wr & a_scr) scratch_reg <= pwdata[7:0];
      if (wr & a_evm) evm <= pwdata[3:0];
      if (wr_fcr) begin
        fen     <= fcr_fen;
        tx_trig <= pwdata[5:4];
        rx_trig <= pwdata[7:6];
      end
    end
  end

  //------------------------------------------------------------
  // Sticky flags: a new event beats a same-cycle clear
  //------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_ovr <= 1'b0;
      err_par <= 1'b0;
      err_frm <= 1'b0;
      evs     <= 4'h0;
      irq     <= 1'b0;
      txd     <= 1'b1;
    end else begin
      err_ovr <= set_ovr | (err_ovr & ~rd_lsr);
      err_par <= set_par | (err_par & ~rd_lsr);
      err_frm <= set_frm | (err_frm & ~rd_lsr);
      evs     <= src | (evs & ~((wr & a_evs) ? pwdata[3:0] : 4'h0));
      irq     <= |(evs & evm);
      txd     <= tx_line & ~lctl[LC_BRK];
    end
  end
endmodule

// file: sim/usp_serial_peer.sv
/* Serial peer on the far side of rxd and txd.
   Assumes divisor 1: a bit lasts 16 pclk cycles. */
`timescale 1ns/1ps
module usp_serial_peer (
  // Line
  input  wire logic pclk,
  input  wire logic txd,
  output      logic rxd
);
  logic [7:0] got; // Last byte seen on txd
  int         cnt; // Frames seen on txd
  // Sends one idle-high 8N1 frame, LSB first
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge pclk) rxd <= f[i];
      repeat (15) @(posedge pclk);
    end
  endtask
  // Decodes txd at mid-bit; bad stop spoils the byte
  initial begin
    rxd = 1'b1;
    cnt = 0;
    forever begin
      @(negedge txd);
      repeat (8) @(posedge pclk);
      for (int i = 0; i < 9; i++) begin
        repeat (16) @(posedge pclk);
        if (i < 8) got[i] = txd;
      end
      if (txd !== 1'b1) got = 'x;
      cnt++;
    end
  end
endmodule

// file: sim/usp_properties.sv
/* Pin checker of the serial port.
   Assumes the bench never sets the break bit. */
`timescale 1ns/1ps
module usp_properties (
  // Watched pins
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        txd,
  input wire logic        irq
);
  import usp_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_time_a: assert property ($rose(penable) && psel |=> pready)
    else $error("pready late");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready long");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr alone");
  read_upper_a: assert property (pready && !pwrite |-> !prdata[31:8])
    else $error("upper bits set");
  err_zero_a: assert property (pslverr && !pwrite |-> !prdata)
    else $error("error read not 0");
  map_ok_a: assert property (pready && paddr == ADDR_IIF |-> !pslverr)
    else $error("mapped refused");
  low_hold_a: assert property ($fell(txd) |-> !txd [*8])
    else $error("short low bit");
  high_hold_a: assert property ($rose(txd) |-> txd [*8])
    else $error("short high bit");
  reset_idle_a: assert property ($rose(presetn) |-> txd && !irq)
    else $error("not idle");
  cover property (pslverr);
  cover property ($rose(irq));
  cover property ($fell(txd));
endmodule
bind usp_top usp_properties usp_properties_i (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .txd, .irq);

// file: sim/test_uart_serial_port.sv
/* Bench: APB master tasks and a serial peer.
   Assumes divisor 1 keeps frames short. */
`timescale 1ns/1ps
module test_uart_serial_port;
  import usp_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        rxd, txd, irq, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  int          fail_count, checked, n;
  usp_top usp_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .rxd, .txd, .irq);
  usp_serial_peer usp_serial_peer_i (.pclk, .txd, .rxd);
  //----------
  // Tasks
  //----------
  task wrap_up;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %0t got %h want %h", $time, s, e);
    end
  endtask
  // Setup, access, hold until pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk) penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    {q, err} = {prdata, pslverr};
    {psel, penable} <= 2'b0;
    if (n >= 20) begin
      fail_count++;
      wrap_up;
    end
  endtask
  // Bounded wait for frames at the peer
  task wait_peer(input int c);
    n = 0;
    while (usp_serial_peer_i.cnt < c && n < 4000) begin
      @(posedge pclk);
      n++;
    end
    chk(usp_serial_peer_i.cnt, c);
    if (n >= 4000) wrap_up;
  endtask
  task t_reset;
    apb(0, ADDR_LCTL, 0); chk(q, 32'h3);
    apb(1, ADDR_LCTL, 32'h1F); apb(0, ADDR_LCTL, 0); chk(q, 32'h1F);
    apb(1, ADDR_LCTL, 32'h3); apb(0, ADDR_IIF, 0); chk(q, 32'h1);
    apb(1, ADDR_BUF, 32'h55); repeat (300) @(posedge pclk);
    chk(usp_serial_peer_i.cnt, 0);
    apb(0, 8'h40, 0); chk(q, 0);
    chk(err, 1);
    $display("t_reset done");
  endtask
  task t_tx;
    apb(1, ADDR_LCTL, 32'h83); apb(1, ADDR_BUF, 1); apb(1, ADDR_IEN, 0);
    apb(0, ADDR_BUF, 0); chk(q, 32'h1);
    apb(1, ADDR_LCTL, 32'h3);
    wait_peer(1); chk(usp_serial_peer_i.got, 8'h55);
    apb(1, ADDR_IIF, 32'h1); apb(1, ADDR_BUF, 32'hA5);
    wait_peer(2); chk(usp_serial_peer_i.got, 8'hA5);
    $display("t_tx done");
  endtask
  task t_rx;
    apb(1, ADDR_IEN, 32'h3); apb(1, ADDR_EVM, 32'h2);
    usp_serial_peer_i.send(8'h3C);
    for (int i = 0; i < 400 && irq !== 1'b1; i++) @(posedge pclk);
    chk(irq, 1);
    if (irq !== 1'b1) wrap_up;
    apb(0, ADDR_IIF, 0); chk(q[3:0], IID_RXAV);
    apb(0, ADDR_BUF, 0); chk(q, 32'h3C);
    apb(1, ADDR_EVS, 32'h2); apb(0, ADDR_IIF, 0); chk(q[3:0], IID_TX_HOLDING_EMPTY);
    chk(irq, 0);
    $display("t_rx done");
  endtask
  task t_tx_holding_empty;
    apb(1, ADDR_IIF, 32'h21); apb(1, ADDR_IEN, 32'h82);
    apb(0, ADDR_IIF, 0); chk(q[3:0], IID_TX_HOLDING_EMPTY);
    for (int i = 0; i < 8; i++) apb(1, ADDR_BUF, i);
    apb(0, ADDR_IIF, 0); chk(q[3:0], IID_NONE);
    wait_peer(10); chk(usp_serial_peer_i.got, 8'h7);
    apb(0, ADDR_IIF, 0); chk(q[3:0], IID_TX_HOLDING_EMPTY);
    $display("t_tx_holding_empty done");
  endtask
  // One byte, three below the four-byte receive trigger, must end in a timeout
  task t_tout;
    apb(1, ADDR_IIF, 32'h41); apb(1, ADDR_IEN, 32'h1);
    usp_serial_peer_i.send(8'h81); repeat (700) @(posedge pclk);
    apb(0, ADDR_IIF, 0); chk(q[3:0], IID_TOUT);
    apb(0, ADDR_BUF, 0); chk(q, 32'h81);
    $display("t_tout done");
  endtask
  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {fail_count, checked} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_tx;
    t_rx;
    t_tx_holding_empty;
    t_tout;
    wrap_up;
  end
endmodule
